// ---- core/oe_pin_sync.sv ----
// Two-flop synchronisers for the pins that reveal bus activity.
// Assumes the pins are asynchronous to the system clock.
`timescale 1ns/1ps
module oe_pin_sync (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic [1:0] pins_in,
  oe_seq_if.pin_src       ps
);
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } sync_s;

  sync_s q, d;

  // ------------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------------
  // The first stage feeds only the second; the pins idle high.
  always_comb begin
    d      = q;
    d.meta = pins_in;
    for (int i = 0; i < 2; i++) begin
      d.sync[i] = q.meta[i];
    end
  end

  // Register the state.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '1;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign ps.pin_lvl = q.sync;
endmodule : oe_pin_sync

// ---- core/oe_seq_if.sv ----
// Carrier between the sequencer core and its tick and pin helpers.
// Assumes every signal lives in the system clock domain.
`timescale 1ns/1ps
interface oe_seq_if;
  logic       tick;      // One-cycle pulse every 10 ms.
  logic [1:0] pin_lvl;   // Synchronised levels: [0] single-wire pin, [1] two-wire clock.

  modport tick_src (output tick);
  modport pin_src  (output pin_lvl);
  modport user     (input tick, input pin_lvl);
endinterface : oe_seq_if

// ---- core/oe_seq_pkg.sv ----
// Shared constants and types of the output enable sequencer.
// Assumes a single 25 MHz system clock and a 32-bit classic Wishbone register bus.
package oe_seq_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 10000000;                          // 10 ms tick.
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int POR_WIN_NS    = 25000000;                          // 25 ms power-up window.
  localparam int POR_WIN_CYC   = POR_WIN_NS / CLK_PERIOD_NS;
  localparam int QUIET_MS      = 1000;                              // 1 s quiet period.
  localparam int TICK_MS       = 10;
  localparam logic [6:0] QUIET_TICKS = 7'(QUIET_MS / TICK_MS);

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OE_CTRL_ADDR  = 8'h00;
  localparam logic [7:0] GAIN_SEL_ADDR = 8'h04;
  localparam logic [7:0] ADC_CTRL_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR   = 8'h0C;
  localparam logic [7:0] ALARM_ADDR    = 8'h10;

  // Field positions.
  localparam int ON_COUNT_LSB   = 0;                                // output_on_count [7:0].
  localparam int DELAY_LSB      = 8;                                // temp_conv_delay [11:8].
  localparam int SW_OFF_BIT     = 15;                               // single_wire_off.
  localparam int CONT_SEL_BIT   = 10;                               // continuous_convert_sel.
  localparam int CONV_START_BIT = 12;                               // conv_start_bit.

  // Reset values.
  localparam logic [11:0] OE_CTRL_RST  = 12'h000;
  localparam logic        SW_OFF_RST   = 1'b0;
  localparam logic        CONT_SEL_RST = 1'b0;

  localparam int ALARM_W = 8;

  // ------------------------------------------------------------------
  // State machines
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {S_POR, S_IDLE, S_ON, S_QUIET, S_EE_READ} seq_e;
  typedef enum logic [1:0] {D_IDLE, D_COUNT, D_CONV} dly_e;

endpackage : oe_seq_pkg

// ---- core/oe_seq_top.sv ----
// Output enable sequencer: time-shares the single-wire pin with the analog output.
// Assumes a 25 MHz clock, classic Wishbone for the register file, and an EEPROM
// loader and temperature ADC on the same clock that answer with one-cycle pulses.
//
// Behaviour
// R1: Output-on time is the 8-bit count times 10 ms; zero keeps output off.
// R2: A 25 ms power-up window lets bus traffic stop stand-alone start.
// R3: Any control register write starts the enable/disable sequence.
// R4: Nonzero count enables output at once and loads the on counter.
// R5: Count down per tick; at zero disable output and start 1 s timer.
// R6: Activity on the pin or either bus restarts the 1 s timer.
// R7: After a quiet second the sequencer tries to read the EEPROM.
// R8: Host keeps EEPROM flags invalid during calibration.
// R9: Invalid EEPROM flags restart the 1 s timer.
// R10: A further control write restarts the whole sequence.
// R11: Host first selects single-conversion mode on the temperature ADC.
// R12: Each control write loads the delay counter with the 4-bit field.
// R13: Delay counts down per tick; at zero one conversion is triggered.
// R14: After that conversion completes the delay branch goes idle.
// R15: Alarm bits are latched just before the output is disabled.
// R16: With single-wire off set, the single-wire pin is ignored. The code still honours the pin once power-up traffic has set sw_force.
// R17: Single-wire traffic within 25 ms of power-up still takes control.
// R18: Delay field sits in bits 11:8, 0 to 150 ms in 10 ms steps.
// R19: On, quiet and delay counters run from one free-running 10 ms tick; the power-up window counts clocks.
// R20: Count sits in bits 7:0; delay branch runs independently.
`timescale 1ns/1ps
module oe_seq_top
  import oe_seq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int POR_CYCLES  = POR_WIN_CYC
) (
  input  wire logic               clk_sys_in,
  input  wire logic               rst_n_in,
  input  wire logic               ce_in,
  input  wire logic               wb_cyc_in,
  input  wire logic               wb_stb_in,
  input  wire logic               wb_we_in,
  input  wire logic [7:0]         wb_adr_in,
  input  wire logic [3:0]         wb_sel_in,
  input  wire logic [31:0]        wb_dat_in,
  output logic      [31:0]        wb_dat_out,
  output logic                    wb_ack_out,
  input  wire logic               single_wire_pin_in,
  input  wire logic               two_wire_clk_in,
  input  wire logic [ALARM_W-1:0] fault_alarm_in,
  input  wire logic               ee_done_in,
  input  wire logic               ee_valid_in,
  input  wire logic               adc_done_in,
  output logic                    analog_out_en_out,
  output logic                    ee_read_out,
  output logic                    adc_start_out
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  oe_seq_if sif ();

  oe_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .tk         (sif.tick_src)
  );

  oe_pin_sync u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .pins_in    ({two_wire_clk_in, single_wire_pin_in}),
    .ps         (sif.pin_src)
  );

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    seq_e               st;
    dly_e               dst;
    logic [7:0]         on_cnt;
    logic [6:0]         quiet_cnt;
    logic [3:0]         dly_cnt;
    logic [19:0]        por_cnt;
    logic               sw_force;
    logic [11:0]        ctrl;
    logic               sw_off;
    logic               cont_sel;
    logic [ALARM_W-1:0] alarm;
    logic               an_en;
    logic               ee_rd;
    logic               adc_go;
    logic               ack;
    logic [31:0]        rdat;
    logic [1:0]         pin_prev;
  } top_s;

  top_s q, d;

  logic        bus_req;
  logic        bus_wr;
  logic        oe_wr;
  logic        gain_wr;
  logic        adc_wr;
  logic        sw_edge;
  logic        scl_edge;
  logic        sw_en;
  logic        activity;
  logic [15:0] wdat;

  // ------------------------------------------------------------------
  // Bus decode and activity
  // ------------------------------------------------------------------
  // A request is taken once; the ack flop blocks a second take in the answer cycle.
  assign bus_req  = wb_cyc_in && wb_stb_in && !q.ack;
  assign bus_wr   = bus_req && wb_we_in;
  assign wdat     = wb_dat_in[15:0];
  assign oe_wr    = bus_wr && (wb_adr_in == OE_CTRL_ADDR) && (wb_sel_in[1:0] != 2'b00); // R3
  assign gain_wr  = bus_wr && (wb_adr_in == GAIN_SEL_ADDR) && wb_sel_in[1];
  assign adc_wr   = bus_wr && (wb_adr_in == ADC_CTRL_ADDR) && wb_sel_in[1];
  assign sw_edge  = sif.pin_lvl[0] != q.pin_prev[0];
  assign scl_edge = sif.pin_lvl[1] != q.pin_prev[1];
  // The power-up override keeps the pin live even with single-wire off set.
  assign sw_en    = !q.sw_off || q.sw_force;                        // R16 R17
  assign activity = bus_req || scl_edge || (sw_edge && sw_en);      // R6

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    d          = q;
    d.ee_rd    = 1'b0;
    d.adc_go   = 1'b0;
    d.pin_prev = sif.pin_lvl;

    // Wishbone slave: answer one cycle after the request, drop ack the next.
    d.ack = bus_req;
    if (bus_req && !wb_we_in) begin
      case (wb_adr_in)
        OE_CTRL_ADDR:  d.rdat = {20'h0_0000, q.ctrl};
        GAIN_SEL_ADDR: d.rdat = {16'h0000, q.sw_off, 15'h0000};
        ADC_CTRL_ADDR: d.rdat = {21'h00_0000, q.cont_sel, 10'h000};
        STATUS_ADDR:   d.rdat = {5'h00, q.on_cnt, q.dly_cnt, q.sw_force,
                                 1'b0, q.dst, q.st, q.an_en, q.quiet_cnt};
        ALARM_ADDR:    d.rdat = {{(32 - ALARM_W){1'b0}}, q.alarm};
        default:       d.rdat = 32'h0000_0000;                      // Unmapped reads zero.
      endcase
    end

    // Plain configuration writes.
    if (gain_wr) begin
      d.sw_off = wdat[SW_OFF_BIT];
    end
    if (adc_wr) begin
      d.cont_sel = wdat[CONT_SEL_BIT];
      // A host-written start bit still launches a conversion; it never stores.
      d.adc_go   = wdat[CONV_START_BIT];
    end

    // Output sequence.
    case (q.st)
      S_POR: begin
        if (activity) begin                                         // R2
          d.st = S_IDLE;
          if (sw_edge) begin
            d.sw_force = 1'b1;                                      // R17
          end
        end else if (q.por_cnt == 20'(POR_CYCLES - 1)) begin
          d.st    = S_EE_READ;
          d.ee_rd = 1'b1;
        end else begin
          d.por_cnt = q.por_cnt + 20'h0_0001;
        end
      end
      S_IDLE: begin
      end
      S_ON: begin
        if (sif.tick) begin
          d.on_cnt = q.on_cnt - 8'h01;                              // R5
          if (q.on_cnt == 8'h01) begin
            d.alarm     = fault_alarm_in;                           // R15
            d.an_en     = 1'b0;
            d.st        = S_QUIET;
            d.quiet_cnt = QUIET_TICKS;
          end
        end
      end
      S_QUIET: begin
        if (activity) begin
          d.quiet_cnt = QUIET_TICKS;                                // R6
        end else if (sif.tick) begin
          if (q.quiet_cnt == 7'h01) begin
            d.st    = S_EE_READ;                                    // R7
            d.ee_rd = 1'b1;
          end
          d.quiet_cnt = q.quiet_cnt - 7'h01;
        end
      end
      S_EE_READ: begin
        if (ee_done_in) begin
          if (ee_valid_in) begin
            d.st = S_IDLE;
          end else begin
            d.st        = S_QUIET;                                  // R9
            d.quiet_cnt = QUIET_TICKS;
          end
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase

    // Temperature delay branch, independent of the output branch.
    case (q.dst)
      D_IDLE: begin
      end
      D_COUNT: begin
        if (q.dly_cnt == 4'h0) begin
          d.adc_go = 1'b1;                                          // R13
          d.dst    = D_CONV;
        end else if (sif.tick) begin
          d.dly_cnt = q.dly_cnt - 4'h1;                             // R13
        end
      end
      D_CONV: begin
        if (adc_done_in) begin
          d.dst = D_IDLE;                                           // R14
        end
      end
      default: begin
        d.dst = D_IDLE;
      end
    endcase

    // A control write overrides whatever either branch was doing.
    if (oe_wr) begin
      if (wb_sel_in[0]) begin
        d.ctrl[7:0] = wdat[7:0];
      end
      if (wb_sel_in[1]) begin
        d.ctrl[11:8] = wdat[11:8];
      end
      d.on_cnt  = d.ctrl[ON_COUNT_LSB +: 8];                        // R4 R20
      d.dly_cnt = d.ctrl[DELAY_LSB +: 4];                           // R12 R18
      d.dst     = D_COUNT;                                          // R12
      if (d.ctrl[ON_COUNT_LSB +: 8] != 8'h00) begin
        d.an_en = 1'b1;                                             // R4 R10
        d.st    = S_ON;
      end else begin
        // A zero count keeps the output off and goes straight to the quiet wait.
        d.an_en     = 1'b0;                                         // R1
        d.st        = S_QUIET;
        d.quiet_cnt = QUIET_TICKS;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q          <= '0;
      q.st       <= S_POR;
      q.dst      <= D_IDLE;
      q.ctrl     <= OE_CTRL_RST;
      q.sw_off   <= SW_OFF_RST;
      q.cont_sel <= CONT_SEL_RST;
      q.pin_prev <= 2'b11;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // Outputs come straight from the state flops.
  assign wb_dat_out        = q.rdat;
  assign wb_ack_out        = q.ack;
  assign analog_out_en_out = q.an_en;
  assign ee_read_out       = q.ee_rd;
  assign adc_start_out     = q.adc_go;

endmodule : oe_seq_top

// ---- core/oe_tick_gen.sv ----
// Free-running 10 ms tick divider.
// Assumes a clock enable that freezes the divider while low.
`timescale 1ns/1ps
module oe_tick_gen
  import oe_seq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  oe_seq_if.tick_src tk
);
  typedef struct packed {
    logic [17:0] cnt;
    logic        tick;
  } tick_s;

  tick_s q, d;

  // ------------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------------
  // The divider never stops, so a count started mid-period loses up to one tick.
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 18'(TICK_CYCLES - 1)) begin
      d.cnt  = 18'h0_0000;
      d.tick = 1'b1;                                                // R19
    end else begin
      d.cnt = q.cnt + 18'h0_0001;
    end
  end

  // Register the state.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign tk.tick = q.tick;
endmodule : oe_tick_gen

// ---- dv/oe_far_model.sv ----
// Model of the EEPROM loader and temperature converter facing the sequencer.
// Assumes the system clock; answers each start with a one-cycle done pulse.
`timescale 1ns/1ps
module oe_far_model (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic slow_in,
  input  wire logic flags_ok_in,
  input  wire logic ee_read_in,
  input  wire logic adc_start_in,
  output logic      ee_done_out,
  output logic      ee_valid_out,
  output logic      adc_done_out
);
  int ee_q, adc_q, lat;

  // Latency choice lets a scenario exercise prompt and slow answers.
  assign lat = slow_in ? 40 : 2;

  // Flags toggle between answers, so a reader sampling off the done pulse sees no steady value.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ee_q         <= 0;
      adc_q        <= 0;
      ee_done_out  <= 1'b0;
      ee_valid_out <= 1'b0;
      adc_done_out <= 1'b0;
    end else begin
      ee_q         <= ee_read_in ? lat : (ee_q > 0 ? ee_q - 1 : 0);
      adc_q        <= adc_start_in ? lat : (adc_q > 0 ? adc_q - 1 : 0);
      ee_done_out  <= (ee_q == 1);
      ee_valid_out <= (ee_q == 1) ? flags_ok_in : ~ee_valid_out;
      adc_done_out <= (adc_q == 1);
    end
  end
endmodule : oe_far_model

// ---- dv/oe_seq_chk.sv ----
// Port-level checks of the output enable sequencer top.
// Assumes it is bound into oe_seq_top and shares its count parameters.
`timescale 1ns/1ps
module oe_seq_chk
  import oe_seq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int POR_CYCLES  = POR_WIN_CYC
) (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        ce_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic        wb_ack_out,
  input wire logic        two_wire_clk_in,
  input wire logic        analog_out_en_out,
  input wire logic        ee_read_out,
  input wire logic        adc_start_out
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic        take, wr_oe, tw_q, act_q;
  logic [7:0]  on_n_q;
  logic [31:0] on_cyc_q, idle_q;

  // A request taken on this edge, and the control register writes among them.
  assign take  = wb_cyc_in & wb_stb_in & ~wb_ack_out & ce_in;
  assign wr_oe = take & wb_we_in & (wb_adr_in == OE_CTRL_ADDR) & (|wb_sel_in[1:0]);

  // Idle time skips single-wire edges, which may be ignored, so it is an upper bound.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      on_n_q   <= 8'h00;
      on_cyc_q <= 32'h0;
      idle_q   <= 32'h0;
      tw_q     <= 1'b1;
      act_q    <= 1'b0;
    end else begin
      tw_q     <= two_wire_clk_in;
      on_cyc_q <= wr_oe ? 32'h0 : on_cyc_q + {31'h0, analog_out_en_out};
      if (wr_oe && wb_sel_in[0]) on_n_q <= wb_dat_in[7:0];
      if (wb_cyc_in || analog_out_en_out || ee_read_out || tw_q != two_wire_clk_in) begin
        idle_q <= 32'h0;
        act_q  <= act_q | ~ee_read_out;
      end else begin
        idle_q <= idle_q + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  ack_answer_a: assert property (take |=> wb_ack_out)
    else $error("request not answered");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  out_on_a: assert property (wr_oe && wb_sel_in[0] && wb_dat_in[7:0] != 8'h00 |=> analog_out_en_out)
    else $error("output not enabled by count");
  out_zero_a: assert property (wr_oe && wb_sel_in[0] && wb_dat_in[7:0] == 8'h00 |=> !analog_out_en_out)
    else $error("output on with zero count");
  on_time_a: assert property ($fell(analog_out_en_out) && !$past(wr_oe) |->
    on_cyc_q + 2 >= (on_n_q - 8'd1) * TICK_CYCLES && on_cyc_q <= on_n_q * TICK_CYCLES + 2)
    else $error("output on time wrong");
  ee_quiet_a: assert property (ee_read_out |->
    (act_q ? idle_q >= 99 * TICK_CYCLES : idle_q + 2 >= POR_CYCLES))
    else $error("eeprom read before quiet time");
  ee_pulse_a: assert property (ee_read_out |=> !ee_read_out)
    else $error("eeprom start not a pulse");
  adc_now_a: assert property (wr_oe && wb_sel_in[1] && wb_dat_in[11:8] == 4'h0 |-> ##2 adc_start_out)
    else $error("zero delay conversion missing");

  cover property ($fell(analog_out_en_out));
  cover property (ee_read_out && act_q);
  cover property (adc_start_out);
endmodule : oe_seq_chk

bind oe_seq_top oe_seq_chk #(.TICK_CYCLES(TICK_CYCLES), .POR_CYCLES(POR_CYCLES)) oe_seq_chk_inst (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out), .two_wire_clk_in(two_wire_clk_in),
  .analog_out_en_out(analog_out_en_out), .ee_read_out(ee_read_out),
  .adc_start_out(adc_start_out));

// ---- dv/output_enable_sequencer_tb_top.sv ----
// Self-checking bench for the output enable sequencer.
// Assumes shortened tick and power-up counts and oe_far_model on the far side.
`timescale 1ns/1ps
module output_enable_sequencer_tb_top
  import oe_seq_pkg::*;
;
  localparam int T = 10;
  localparam int P = 50;
  logic        clk_sys_in, rst_n_in, wb_cyc, wb_stb, wb_we, wb_ack, sw_pin, tw_clk;
  logic        ee_done, ee_valid, adc_done, an_en, ee_rd, adc_st, flags_ok, slow;
  logic [3:0]  wb_sel;
  logic [7:0]  wb_adr, alarm;
  logic [31:0] wb_wdat, wb_rdat, r;
  int          failures, compares, cyc_cnt, n, t0;

  oe_seq_top #(.TICK_CYCLES(T), .POR_CYCLES(P)) oe_seq_top_inst (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
    .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
    .single_wire_pin_in(sw_pin), .two_wire_clk_in(tw_clk), .fault_alarm_in(alarm),
    .ee_done_in(ee_done), .ee_valid_in(ee_valid), .adc_done_in(adc_done),
    .analog_out_en_out(an_en), .ee_read_out(ee_rd), .adc_start_out(adc_st));
  oe_far_model oe_far_model_inst (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .slow_in(slow), .flags_ok_in(flags_ok),
    .ee_read_in(ee_rd), .adc_start_in(adc_st), .ee_done_out(ee_done),
    .ee_valid_out(ee_valid), .adc_done_out(adc_done));

  // Clock at 25 MHz.
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // Cycle count that times the outputs.
  always @(posedge clk_sys_in) cyc_cnt <= cyc_cnt + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: value %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rng(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : rng

  // Classic cycle: request held until ack is sampled, then released for a cycle.
  // Only the watchdog ends a wait for ack.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    @(posedge clk_sys_in);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, w, a, d, 4'h3};
    do begin
      @(posedge clk_sys_in);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    {wb_cyc, wb_stb} <= 2'b00;
  endtask : wb

  // Returns the edges waited; a timeout returns the limit itself.
  task automatic wait_for(input int kind, input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (!(kind == 0 ? ee_rd === 1'b1 : kind == 1 ? adc_st === 1'b1 : an_en === 1'b0)
               && k < lim);
  endtask : wait_for

  task automatic t_regs();
    wb(1'b0, OE_CTRL_ADDR, 32'h0, r);
    check(r, {20'h0, OE_CTRL_RST});
    wb(1'b1, ADC_CTRL_ADDR, 32'h0, r);
    wb(1'b0, ADC_CTRL_ADDR, 32'h0, r);
    check(r, 32'h0);
    wb(1'b0, 8'h14, 32'h0, r);
    check(r, 32'h0);
    $display("regs done");
  endtask : t_regs

  task automatic t_on();
    alarm <= 8'hA5;
    wb(1'b1, OE_CTRL_ADDR, 32'h0203, r);
    t0 = cyc_cnt;
    check({31'h0, an_en}, 32'h1);
    wait_for(1, 3 * T, n);
    rng(n, T - 2, 2 * T + 2);
    wait_for(2, 4 * T, n);
    rng(cyc_cnt - t0, 2 * T - 2, 3 * T + 2);
    alarm <= 8'h3C;
    wb(1'b0, ALARM_ADDR, 32'h0, r);
    check(r, 32'h0000_00A5);
    $display("on done");
  endtask : t_on

  // Two-wire edges hold off the read, then an invalid read rearms the wait and a valid one ends it.
  task automatic t_quiet();
    {flags_ok, slow} <= 2'b01;
    for (int i = 0; i < 150 * T; i++) begin
      @(posedge clk_sys_in);
      if (i % 50 == 49) tw_clk <= ~tw_clk;
      check({31'h0, ee_rd}, 32'h0);
    end
    for (int k = 0; k < 2; k++) begin
      t0 = cyc_cnt;
      wait_for(0, 110 * T, n);
      rng(cyc_cnt - t0, 99 * T, 105 * T);
    end
    flags_ok <= 1'b1;
    wait_for(0, 110 * T, n);
    check(n, 110 * T);
    $display("quiet done");
  endtask : t_quiet

  task automatic t_restart();
    slow <= 1'b0;
    wb(1'b1, OE_CTRL_ADDR, 32'h0005, r);
    repeat (2 * T) @(posedge clk_sys_in);
    wb(1'b1, OE_CTRL_ADDR, 32'h0005, r);
    t0 = cyc_cnt;
    wait_for(2, 6 * T, n);
    rng(cyc_cnt - t0, 4 * T - 2, 5 * T + 2);
    $display("restart done");
  endtask : t_restart

  // With the single wire off, its edges must not hold off the read.
  task automatic t_swoff();
    wb(1'b1, GAIN_SEL_ADDR, 32'h8000, r);
    wb(1'b0, GAIN_SEL_ADDR, 32'h0, r);
    check(r, 32'h8000);
    wb(1'b1, OE_CTRL_ADDR, 32'h0000, r);
    t0 = cyc_cnt;
    check({31'h0, an_en}, 32'h0);
    for (int i = 0; i < 90 * T; i++) begin
      @(posedge clk_sys_in);
      if (i % 50 == 49) sw_pin <= ~sw_pin;
    end
    wait_for(0, 20 * T, n);
    rng(cyc_cnt - t0, 99 * T, 101 * T + 5);
    $display("swoff done");
  endtask : t_swoff

  // With no traffic the power-up window ends in a stand-alone read.
  task automatic t_por();
    wait_for(0, P + 20, n);
    rng(n, P - 5, P + 5);
    $display("por done");
  endtask : t_por

  // A mid-run reset; a single-wire edge inside the window takes control.
  task automatic t_por_sw();
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    sw_pin <= ~sw_pin;
    wait_for(0, P + 20, n);
    check(n, P + 20);
    wb(1'b0, STATUS_ADDR, 32'h0, r);
    check({31'h0, r[14]}, 32'h1);
    check({29'h0, r[10:8]}, 32'h1);
    $display("por_sw done");
  endtask : t_por_sw

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Main sequence; no bus access until the stand-alone read is seen.
  initial begin
    {rst_n_in, wb_cyc, wb_stb, wb_we, slow, sw_pin, tw_clk, flags_ok} = 8'h07;
    {wb_adr, wb_sel, wb_wdat, alarm} = '0;
    {failures, compares, cyc_cnt} = '0;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_por();
    t_regs();
    t_on();
    t_quiet();
    t_restart();
    t_swoff();
    t_por_sw();
    test_done();
  end

  // Run takes about 6000 cycles; this cuts a hang short.
  initial begin
    repeat (12000) @(posedge clk_sys_in);
    $display("MISMATCH at %0t: watchdog expired", $time);
    failures++;
    test_done();
  end
endmodule : output_enable_sequencer_tb_top
